// >>> logic/scsr_top.sv
// Sensor configuration serial port, register map and frame sequencer
//
// What the document asks of this block and its host
// RULE_01 - Output data rate is 10x master clock in 10-bit mode, 12x in 12-bit.
// RULE_02 - Host keeps master clock between 5MHz and 48MHz, 40MHz in 12-bit mode.
// RULE_03 - Host reprograms registers 114 and 116 whenever the master clock changes.
// RULE_04 - Overhead lasts (overhead setting + 2*16/outputs) times 129 clocks, setting default 10.
// RULE_05 - Each read-out line lasts 129 times 16/outputs clocks.
// RULE_06 - Next frame exposure runs during read-out of the current frame.
// RULE_07 - Host starts clock, holds reset low, releases it 1us after supplies settle.
// RULE_08 - Host waits 1us after reset release before the first frame request.
// RULE_09 - Upload may start 1us after reset; request only after upload plus settling.
// RULE_10 - Host allows 7ms settling for saturating gain, 20ms for maximum gain.
// RULE_11 - Reset falling edge clears the sequencer and restores every register default.
// RULE_12 - After a running reset host waits 1us plus gain settling before requesting.
// RULE_13 - Serial input bits are sampled on rising serial clock; host stays under 48MHz.
// RULE_14 - Host raises serial select half a period before the first sampled bit.
// RULE_15 - Host holds select one more period and gives a final falling edge.
// RULE_16 - Each access is a 16-bit frame; first bit 1 writes, 0 reads.
// RULE_17 - Then 7 address bits and 8 data bits, both most significant first.
// RULE_18 - Consecutive frames under one held select are each accepted in turn.
// RULE_19 - Host should update registers only while the sensor is idle.
// RULE_20 - Host writes registers 35-38, 40-69, 100-103 only in idle or overhead.
// RULE_21 - Writes are accepted at any time without disturbing the sequencer; the code drops writes while the reset pin is held low.
// RULE_22 - Read data leaves MSB first on falling serial clock edges after address LSB.
// RULE_23 - Host reads temperature registers 126 and 127 in one burst.
// RULE_24 - Reset and frame request are sampled on master clock; host holds one period.
// RULE_25 - A high frame request starts the programmed number of frames, default one.
// RULE_26 - 128-entry map; unimplemented addresses ignore writes and read zero.
`include "scsr_cfg.svh"

module scsr_top (
  input wire logic clock,
  input wire logic nrst,
  input wire scsr_pkg::scsr_spi_t spi_pins,
  input wire logic sensor_reset_low,
  input wire logic frame_req,
  output logic spi_out,
  output scsr_pkg::scsr_status_t status
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register map helpers

  function automatic logic [7:0] cfg_default(input logic [6:0] a);
    logic [7:0] v;
    v = `SCSR_DEF_OTHER;
    case (a)
      `SCSR_ADDR_LINES_LO: v = `SCSR_DEF_LINES_LO;
      `SCSR_ADDR_LINES_HI: v = `SCSR_DEF_LINES_HI;
      `SCSR_ADDR_EXP: v = `SCSR_DEF_EXP;
      `SCSR_ADDR_FRAMES_LO: v = `SCSR_DEF_FRAMES_LO;
      `SCSR_ADDR_FOT_LEN: v = `SCSR_DEF_FOT_LEN;
      default: v = `SCSR_DEF_OTHER;
    endcase
    return v;
  endfunction

  function automatic logic cfg_impl(input logic [6:0] a);
    return ((a >= `SCSR_IMPL_LO_FIRST) && (a <= `SCSR_IMPL_LO_LAST)) || (a >= `SCSR_IMPL_HI_FIRST);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  scsr_pkg::scsr_spi_t spi_s1_q;
  scsr_pkg::scsr_spi_t spi_s2_q;
  logic spi_clk_d_q;
  logic [1:0] pin_s1_q;
  logic [1:0] pin_s2_q;

  // Every pin is asynchronous to the master clock, so two stages before use
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      spi_s1_q <= '0;
      spi_s2_q <= '0;
      spi_clk_d_q <= 1'b0;
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      spi_s1_q <= spi_pins;
      spi_s2_q <= spi_s1_q;
      spi_clk_d_q <= spi_s2_q.clk;
      pin_s1_q <= {sensor_reset_low, frame_req}; // RULE_24
      pin_s2_q <= pin_s1_q; // RULE_24
    end
  end

  logic sres_n;
  logic req_lvl;
  logic sck_rise;
  logic sck_fall;
  assign sres_n = pin_s2_q[`SCSR_PIN_RST];
  assign req_lvl = pin_s2_q[`SCSR_PIN_REQ];
  assign sck_rise = spi_s2_q.clk & ~spi_clk_d_q;
  assign sck_fall = ~spi_s2_q.clk & spi_clk_d_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Serial frame receiver

  logic [4:0] bit_cnt_q;
  logic [15:0] in_q;
  logic [7:0] out_q;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bit_cnt_q <= '0;
      in_q <= '0;
    end else if (!spi_s2_q.en) begin
      bit_cnt_q <= '0;
    end else if (sck_rise && (bit_cnt_q != `SCSR_BITS_FRAME)) begin
      in_q <= {in_q[14:0], spi_s2_q.din}; // RULE_13
      bit_cnt_q <= bit_cnt_q + 5'h01;
    end else if (sck_fall && (bit_cnt_q == `SCSR_BITS_FRAME)) begin
      bit_cnt_q <= '0; // RULE_18
    end
  end

  logic wr_en;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic [6:0] rd_addr;
  logic [7:0] rd_data;
  logic rd_msb;
  logic [7:0] cfg_q [128];

  // The write lands on the closing falling edge, so an aborted frame never writes
  assign wr_en = sck_fall && spi_s2_q.en && (bit_cnt_q == `SCSR_BITS_FRAME) &&
                 (in_q[`SCSR_FLD_CTRL] == `SCSR_CTRL_WRITE); // RULE_16
  assign wr_addr = in_q[`SCSR_FLD_ADDR]; // RULE_17
  assign wr_data = in_q[`SCSR_FLD_DATA]; // RULE_17
  assign rd_addr = in_q[`SCSR_FLD_HADDR];
  assign rd_data = cfg_impl(rd_addr) ? cfg_q[rd_addr] : `SCSR_DEF_OTHER; // RULE_26
  assign rd_msb = rd_data[7];

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      out_q <= '0;
    end else if (!spi_s2_q.en || (sck_fall && (bit_cnt_q == `SCSR_BITS_FRAME))) begin
      out_q <= '0;
    end else if (sck_fall && (bit_cnt_q == `SCSR_BITS_HDR) && !in_q[`SCSR_FLD_HCTRL]) begin
      out_q <= rd_data; // RULE_22
    end else if (sck_fall && (bit_cnt_q > `SCSR_BITS_HDR) && (bit_cnt_q <= `SCSR_BITS_LAST_OUT)) begin
      out_q <= {out_q[6:0], 1'b0}; // RULE_22
    end
  end

  assign spi_out = out_q[7];

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  for (genvar i = 0; i < 128; i++) begin : g_cfg
    localparam logic [7:0] DEF = cfg_default(7'(i));
    always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
        cfg_q[i] <= DEF;
      end else if (!sres_n) begin
        cfg_q[i] <= DEF; // RULE_11
      end else if (wr_en && (wr_addr == 7'(i)) && cfg_impl(7'(i))) begin
        cfg_q[i] <= wr_data; // RULE_21
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Timing derived from the settings

  logic bit12;
  logic [1:0] out_code;
  logic [3:0] ratio;
  logic [8:0] fot_units;
  logic [16:0] fot_cyc;
  logic [16:0] line_cyc;
  logic [16:0] exp_cyc;
  logic [15:0] lines_reg;
  logic [15:0] frames_reg;
  logic [15:0] frames_first;

  // 12-bit conversion is slower, so the output count is forced to four
  assign bit12 = cfg_q[`SCSR_ADDR_BIT_MODE][`SCSR_FLD_BIT12];
  assign out_code = bit12 ? `SCSR_OUT_MODE_12B : cfg_q[`SCSR_ADDR_OUT_MODE][`SCSR_FLD_OUT];
  assign ratio = 4'h1 << out_code;
  assign fot_units = {1'b0, cfg_q[`SCSR_ADDR_FOT_LEN]} + {4'h0, ratio, 1'b0};
  assign fot_cyc = 17'(fot_units) * `SCSR_ROW_CYC; // RULE_04
  assign line_cyc = 17'(ratio) * `SCSR_ROW_CYC; // RULE_05
  assign exp_cyc = 17'(cfg_q[`SCSR_ADDR_EXP]) * `SCSR_ROW_CYC;
  assign lines_reg = {cfg_q[`SCSR_ADDR_LINES_HI], cfg_q[`SCSR_ADDR_LINES_LO]};
  assign frames_reg = {cfg_q[`SCSR_ADDR_FRAMES_HI], cfg_q[`SCSR_ADDR_FRAMES_LO]};
  // A frame count of zero still yields one frame
  assign frames_first = (frames_reg == 16'h0000) ? 16'h0000 : frames_reg - 16'h0001; // RULE_25

  ////////////////////////////////////////////////////////////////////////////////
  // Frame sequencer

  scsr_pkg::scsr_seq_t seq_q;
  scsr_pkg::scsr_seq_t seq_d;

  always_comb begin
    seq_d = seq_q;
    // Exposure timer runs on its own so it can overlap read-out
    if (seq_q.exp_run) begin
      if (seq_q.exp_cnt == 17'h00000) begin
        seq_d.exp_run = 1'b0;
        seq_d.exp_done = 1'b1;
      end else begin
        seq_d.exp_cnt = seq_q.exp_cnt - 17'h00001;
      end
    end
    unique case (seq_q.state)
      scsr_pkg::st_idle: begin
        if (req_lvl) begin
          seq_d.frames = frames_first; // RULE_25
          seq_d.exp_cnt = exp_cyc;
          seq_d.exp_run = 1'b1;
          seq_d.exp_done = 1'b0;
          seq_d.state = scsr_pkg::st_expose;
        end
      end
      scsr_pkg::st_expose: begin
        if (seq_q.exp_done) begin
          seq_d.state = scsr_pkg::st_fot;
          seq_d.cnt = fot_cyc - 17'h00001; // RULE_04
          seq_d.exp_done = 1'b0;
        end
      end
      scsr_pkg::st_fot: begin
        if (seq_q.cnt != 17'h00000) begin
          seq_d.cnt = seq_q.cnt - 17'h00001;
        end else begin
          seq_d.state = scsr_pkg::st_readout;
          seq_d.cnt = line_cyc - 17'h00001; // RULE_05
          seq_d.lines = lines_reg;
          seq_d.more = (seq_q.frames != 16'h0000);
          if (seq_q.frames != 16'h0000) begin
            seq_d.frames = seq_q.frames - 16'h0001;
            seq_d.exp_cnt = exp_cyc; // RULE_06
            seq_d.exp_run = 1'b1; // RULE_06
          end
        end
      end
      scsr_pkg::st_readout: begin
        if (seq_q.cnt != 17'h00000) begin
          seq_d.cnt = seq_q.cnt - 17'h00001;
        end else if (seq_q.lines > 16'h0001) begin
          seq_d.lines = seq_q.lines - 16'h0001;
          seq_d.cnt = line_cyc - 17'h00001; // RULE_05
        end else if (!seq_q.more) begin
          seq_d.state = scsr_pkg::st_idle;
        end else if (seq_q.exp_done) begin
          seq_d.state = scsr_pkg::st_fot; // RULE_06
          seq_d.cnt = fot_cyc - 17'h00001;
          seq_d.exp_done = 1'b0;
        end else begin
          seq_d.state = scsr_pkg::st_expose;
        end
      end
    endcase
  end

  // Holding the clear while the reset pin stays low also covers its falling edge
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      seq_q <= '0;
    end else if (!sres_n) begin
      seq_q <= '0; // RULE_11
    end else begin
      seq_q <= seq_d;
    end
  end

  assign status.idle = (seq_q.state == scsr_pkg::st_idle);
  assign status.exposing = seq_q.exp_run;
  assign status.in_fot = (seq_q.state == scsr_pkg::st_fot);
  assign status.readout = (seq_q.state == scsr_pkg::st_readout);
  assign status.rate_mult = bit12 ? `SCSR_RATE_12 : `SCSR_RATE_10; // RULE_01
  assign status.frames_left = seq_q.frames;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence s_read_launch;
    sck_fall && spi_s2_q.en && (bit_cnt_q == `SCSR_BITS_HDR) && !in_q[`SCSR_FLD_HCTRL];
  endsequence

  sequence s_fot_exit;
    sres_n && (seq_q.state == scsr_pkg::st_fot) && (seq_q.cnt == 17'h00000);
  endsequence

  AST_RATE_MODE: assert property ( // RULE_01
    bit12 |-> (status.rate_mult == `SCSR_RATE_12) && (ratio == 4'h4))
    else $error("rate or output count wrong in 12-bit mode");

  AST_FOT_LOAD: assert property ( // RULE_04
    sres_n && (seq_q.state == scsr_pkg::st_expose) && seq_q.exp_done |=>
      (seq_q.state == scsr_pkg::st_fot) && (seq_q.cnt == $past(fot_cyc) - 17'h00001))
    else $error("overhead period loaded with wrong length");

  AST_LINE_TIME: assert property ( // RULE_05
    s_fot_exit |=> (seq_q.state == scsr_pkg::st_readout) && (seq_q.cnt == $past(line_cyc) - 17'h00001))
    else $error("line time wrong at read-out start");

  AST_OVERLAP: assert property ( // RULE_06
    s_fot_exit ##0 (seq_q.frames != 16'h0000) |=> seq_q.exp_run && seq_q.more)
    else $error("next exposure did not start with read-out");

  AST_SEQ_CLEAR: assert property ( // RULE_11
    !sres_n |=> status.idle && (cfg_q[`SCSR_ADDR_FOT_LEN] == `SCSR_DEF_FOT_LEN))
    else $error("sensor reset did not restore defaults");

  AST_SHIFT_IN: assert property ( // RULE_13
    spi_s2_q.en && sck_rise && (bit_cnt_q < `SCSR_BITS_FRAME) |=>
      (bit_cnt_q == $past(bit_cnt_q) + 5'h01) && (in_q[0] == $past(spi_s2_q.din)))
    else $error("serial bit not taken on rising edge");

  AST_WRITE: assert property ( // RULE_16
    wr_en && cfg_impl(wr_addr) && sres_n |=> cfg_q[$past(wr_addr)] == $past(wr_data))
    else $error("write frame did not update register");

  AST_READ_MSB: assert property ( // RULE_22
    s_read_launch |=> spi_out == $past(rd_msb))
    else $error("read data MSB not launched");

  AST_UNIMP_READ: assert property ( // RULE_26
    s_read_launch ##0 !cfg_impl(rd_addr) |=> !spi_out)
    else $error("unimplemented address read non-zero");

  AST_START: assert property ( // RULE_25
    sres_n && status.idle && req_lvl |=>
      (seq_q.state == scsr_pkg::st_expose) && (seq_q.frames == $past(frames_first)))
    else $error("frame request did not start sequence");

endmodule

// >>> logic/scsr_cfg.svh
// Offsets, field positions, reset values and timing figures of the configuration port and sequencer
`ifndef SCSR_CFG_SVH
`define SCSR_CFG_SVH
`define SCSR_ADDR_LINES_LO 7'h01
`define SCSR_ADDR_LINES_HI 7'h02
`define SCSR_ADDR_EXP 7'h2A
`define SCSR_ADDR_FRAMES_LO 7'h46
`define SCSR_ADDR_FRAMES_HI 7'h47
`define SCSR_ADDR_OUT_MODE 7'h48
`define SCSR_ADDR_FOT_LEN 7'h49
`define SCSR_ADDR_BIT_MODE 7'h6F
`define SCSR_IMPL_LO_FIRST 7'h01
`define SCSR_IMPL_LO_LAST 7'h4F
`define SCSR_IMPL_HI_FIRST 7'h64
`define SCSR_DEF_LINES_LO 8'h40
`define SCSR_DEF_LINES_HI 8'h04
`define SCSR_DEF_EXP 8'h10
`define SCSR_DEF_FRAMES_LO 8'h01
`define SCSR_DEF_FOT_LEN 8'h0A
`define SCSR_DEF_OTHER 8'h00
`define SCSR_FLD_BIT12 0
`define SCSR_FLD_OUT 1:0
`define SCSR_OUT_MODE_12B 2'h2
`define SCSR_ROW_CYC 17'h00081
`define SCSR_RATE_10 4'hA
`define SCSR_RATE_12 4'hC
`define SCSR_BITS_HDR 5'h08
`define SCSR_BITS_LAST_OUT 5'h0F
`define SCSR_BITS_FRAME 5'h10
`define SCSR_FLD_CTRL 15
`define SCSR_FLD_ADDR 14:8
`define SCSR_FLD_DATA 7:0
`define SCSR_FLD_HCTRL 7
`define SCSR_FLD_HADDR 6:0
`define SCSR_CTRL_WRITE 1'h1
`define SCSR_PIN_RST 1
`define SCSR_PIN_REQ 0
`endif

// >>> logic/scsr_pkg.sv
// Types shared by the configuration port and sequencer
package scsr_pkg;
  typedef enum logic [1:0] {st_idle, st_expose, st_fot, st_readout} scsr_state_t;
  typedef struct packed {
    logic clk;
    logic en;
    logic din;
  } scsr_spi_t;
  typedef struct packed {
    scsr_state_t state;
    logic [16:0] cnt;
    logic [16:0] exp_cnt;
    logic [15:0] lines;
    logic [15:0] frames;
    logic more;
    logic exp_run;
    logic exp_done;
  } scsr_seq_t;
  typedef struct packed {
    logic idle;
    logic exposing;
    logic in_fot;
    logic readout;
    logic [3:0] rate_mult;
    logic [15:0] frames_left;
  } scsr_status_t;
endpackage

// >>> verif/scsr_host_model.sv
// Host controller model driving the configuration serial port
module scsr_host_model (
  input wire logic clock,
  input wire logic spi_out,
  output scsr_pkg::scsr_spi_t spi
);
  timeunit 1ns;
  timeprecision 1ps;

  // Eight master clocks per phase, well above the three the port needs to see a level
  localparam int HALF = 8;

  initial begin
    spi = '0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic half_wait();
    repeat (HALF) @(negedge clock);
  endtask

  task automatic open_sel();
    spi.en = 1'b1;
    half_wait();
  endtask

  // No pull on the data line, so it shows the inverse of the last bit once released
  task automatic close_sel();
    half_wait();
    half_wait();
    spi.en = 1'b0;
    spi.din = ~spi.din;
    // Select stays low for a phase so two accesses in a row never merge into a burst
    half_wait();
  endtask

  // Serial clock stands low between frames; read bits are taken just before each rise
  task automatic frame(input logic [15:0] word, output logic [7:0] rd);
    rd = 8'h00;
    for (int n = 0; n < 16; n++) begin
      spi.din = word[15 - n];
      half_wait();
      if (n >= 8) begin
        rd = {rd[6:0], spi_out};
      end
      spi.clk = 1'b1;
      half_wait();
      spi.clk = 1'b0;
    end
  endtask
endmodule

// >>> verif/tb_top.sv
// Self-checking bench for the configuration port and frame sequencer
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // One microsecond of master clock at the 8 ns bench period
  localparam int ONE_US = 125;

  typedef struct {logic wr; logic [6:0] addr; logic [7:0] wdata; logic [7:0] exp;} scsr_row_t;

  logic clock;
  logic nrst;
  logic sensor_reset_low;
  logic frame_req;
  logic spi_out;
  scsr_pkg::scsr_spi_t spi_pins;
  scsr_pkg::scsr_status_t status;
  int miscompares;
  int num_checks;
  int n_exp;
  int n_fot;
  int n_ro;
  int n_ovl;
  logic [7:0] rd;
  scsr_row_t rows [14] = '{
    '{1'b0, 7'h01, 8'h00, 8'h40}, '{1'b0, 7'h02, 8'h00, 8'h04}, '{1'b0, 7'h2A, 8'h00, 8'h10},
    '{1'b0, 7'h46, 8'h00, 8'h01}, '{1'b0, 7'h49, 8'h00, 8'h0A}, '{1'b0, 7'h47, 8'h00, 8'h00},
    '{1'b1, 7'h49, 8'h03, 8'h03}, '{1'b1, 7'h4E, 8'h3C, 8'h3C}, '{1'b1, 7'h7F, 8'hA5, 8'hA5},
    '{1'b1, 7'h50, 8'h5A, 8'h00}, '{1'b1, 7'h00, 8'hFF, 8'h00}, '{1'b1, 7'h63, 8'h77, 8'h00},
    '{1'b1, 7'h72, 8'h03, 8'h03}, '{1'b1, 7'h74, 8'h0C, 8'h0C}
  };

  scsr_top dut (.clock(clock), .nrst(nrst), .spi_pins(spi_pins), .sensor_reset_low(sensor_reset_low),
    .frame_req(frame_req), .spi_out(spi_out), .status(status));
  scsr_host_model host (.clock(clock), .spi_out(spi_out), .spi(spi_pins));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
    host.open_sel();
    host.frame({1'b1, a, d}, rd);
    host.close_sel();
  endtask

  task automatic rd_reg(input logic [6:0] a);
    host.open_sel();
    host.frame({1'b0, a, 8'h00}, rd);
    host.close_sel();
  endtask

  // Counts the cycles spent in each phase from the request until the sequencer is idle again
  task automatic run_frame();
    int k;
    logic started;
    n_exp = 0;
    n_fot = 0;
    n_ro = 0;
    n_ovl = 0;
    k = 0;
    started = 1'b0;
    frame_req = 1'b1;
    while (!(started && status.idle === 1'b1) && k < 40000) begin
      @(negedge clock);
      if (k == 2) begin
        frame_req = 1'b0;
      end
      started |= (status.idle === 1'b0);
      n_exp += int'(status.exposing === 1'b1);
      n_fot += int'(status.in_fot === 1'b1);
      n_ro += int'(status.readout === 1'b1);
      n_ovl += int'(status.exposing === 1'b1 && status.readout === 1'b1);
      k++;
    end
    if (k >= 40000) begin
      miscompares++;
      give_verdict();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    nrst = 1'b0;
    sensor_reset_low = 1'b0;
    frame_req = 1'b0;
    miscompares = 0;
    num_checks = 0;
    repeat (8) @(negedge clock);
    check("idle at reset", status.idle, 1'b1);
    check("rate at reset", status.rate_mult, 4'hA);
    check("frames_left at reset", status.frames_left, 16'h0000);
    check("spi_out at reset", spi_out, 1'b0);
    nrst = 1'b1;
    repeat (ONE_US) @(negedge clock);
    sensor_reset_low = 1'b1;
    repeat (ONE_US) @(negedge clock);
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        wr_reg(rows[i].addr, rows[i].wdata);
      end
      rd_reg(rows[i].addr);
      check("register readback", rd, rows[i].exp);
    end
    check("spi_out after read", spi_out, 1'b0);
    // Two writes then two reads, each pair under one held select
    host.open_sel();
    host.frame({1'b1, 7'h7F, 8'h11}, rd);
    host.frame({1'b1, 7'h7E, 8'h22}, rd);
    host.close_sel();
    // The result pair at the top of the map is also read as one burst
    host.open_sel();
    host.frame({1'b0, 7'h7E, 8'h00}, rd);
    check("burst read first", rd, 8'h22);
    host.frame({1'b0, 7'h7F, 8'h00}, rd);
    check("burst read second", rd, 8'h11);
    host.close_sel();
    wr_reg(7'h6F, 8'h01);
    check("rate in 12-bit", status.rate_mult, 4'hC);
    wr_reg(7'h6F, 8'h00);
    check("rate in 10-bit", status.rate_mult, 4'hA);
    // One line, one-row exposure, zero overhead setting: every output mode in turn
    wr_reg(7'h01, 8'h01);
    wr_reg(7'h02, 8'h00);
    wr_reg(7'h2A, 8'h01);
    wr_reg(7'h49, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr_reg(7'h48, 8'(m));
      run_frame();
      check("overhead cycles", n_fot, 2 * (1 << m) * 129);
      check("line cycles", n_ro, (1 << m) * 129);
      check("exposure cycles", n_exp, 130);
    end
    wr_reg(7'h48, 8'h00);
    wr_reg(7'h46, 8'h02);
    run_frame();
    check("two frame read-out", n_ro, 258);
    check("two frame overhead", n_fot, 516);
    check("exposure during read-out", n_ovl != 0, 1'b1);
    // Sensor reset in mid-frame must stop the sequencer and restore the defaults
    frame_req = 1'b1;
    repeat (8) @(negedge clock);
    frame_req = 1'b0;
    check("frames left in run", status.frames_left, 16'h0001);
    // An always-writable register takes a write while the frames run
    wr_reg(7'h4F, 8'h33);
    rd_reg(7'h4F);
    check("write during run", rd, 8'h33);
    check("busy before sensor reset", status.idle, 1'b0);
    sensor_reset_low = 1'b0;
    repeat (6) @(negedge clock);
    check("idle in sensor reset", status.idle, 1'b1);
    check("exposure stopped", status.exposing, 1'b0);
    sensor_reset_low = 1'b1;
    repeat (ONE_US) @(negedge clock);
    rd_reg(7'h49);
    check("overhead default back", rd, 8'h0A);
    rd_reg(7'h46);
    check("frame count default back", rd, 8'h01);
    rd_reg(7'h2A);
    check("exposure default back", rd, 8'h10);
    // Gain never leaves its default here, so the settling part of the wait is nil
    repeat (ONE_US) @(negedge clock);
    frame_req = 1'b1;
    repeat (4) @(negedge clock);
    frame_req = 1'b0;
    check("restart after sensor reset", status.exposing, 1'b1);
    give_verdict();
  end
endmodule
